/* tle_pkg.sv */
// constants, types and decode helpers for the transmit line encoder
//------------------------------------------------------------------------------
// Function
// - transmit path runs single-rail or dual-rail as the rail format input selects.
// - in hardware control a low code pin gives HDB3 or B8ZS, a high one gives AMI.
// - in host control a one in the code bit selects AMI, zero keeps substitution.
// - transmit data always leaves as bipolar positive and negative line pulses.
// - data is sampled on the falling clock edge when edge select is 0, rising when 1.
// - zero substitution only in single-rail; dual-rail rails pass straight through.
// - E1 with HDB3 replaces each run of four zeros by 000V or B00V.
// - 000V after an odd pulse count since last substitution, B00V after an even count.
// - T1 with B8ZS replaces eight zeros by 000VB0VB, violations follow the last pulse.
// - failure flag rises after more than 128 idle cycles, falls on a valid pulse.
// - the failure state is a status bit; with enable set each change raises an interrupt.
// - a five-bit selector picks five fixed T1 shapes or the arbitrary pulse.
// - E1 mode when both upper selector bits are one, T1/J1 otherwise.
// - 01110 to 10010 T1 gain build-outs, 10011 arbitrary, 111xx E1 modes with HDB3.
// - pulse shape and width are timed from the master clock, not the transmit clock.
// - the arbitrary T1 pulse is eight segments, each seven-bit magnitude plus sign.
//------------------------------------------------------------------------------
package tle_pkg;

  // line symbols held in the substitution delay line
  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_ONE  = 2'b01,
    SYM_VIOL = 2'b11,
    SYM_BAL  = 2'b10
  } tle_sym_e;

  // shaper sequencing
  typedef enum logic {
    SHP_IDLE = 1'b0,
    SHP_RUN  = 1'b1
  } tle_shape_e;

  localparam int          DELAY_DEPTH    = 8;
  localparam logic [3:0]  HDB3_RUN       = 4'h4;
  localparam logic [3:0]  B8ZS_RUN       = 4'h8;
  localparam logic [3:0]  RUN_SAT        = 4'hf;
  localparam logic [7:0]  IDLE_LIMIT     = 8'h80;
  localparam logic [6:0]  FIXED_MAG      = 7'h7f;
  localparam logic [2:0]  LAST_SEGMENT   = 3'h7;

  // HDB3 slot positions, newest zero in slot 0
  localparam int          HDB3_V_SLOT    = 0;
  localparam int          HDB3_B_SLOT    = 3;
  // B8ZS slot positions for 000VB0VB, oldest zero in slot 7
  localparam int          B8ZS_V1_SLOT   = 4;
  localparam int          B8ZS_B1_SLOT   = 3;
  localparam int          B8ZS_V2_SLOT   = 1;
  localparam int          B8ZS_B2_SLOT   = 0;

  // selector equalizer_buildout_select
  localparam logic [4:0]  SEL_T1S_FIRST  = 5'h08;
  localparam logic [4:0]  SEL_T1S_ARB    = 5'h0d;
  localparam logic [4:0]  SEL_T1G_FIRST  = 5'h0e;
  localparam logic [4:0]  SEL_T1G_ARB    = 5'h13;
  localparam logic [4:0]  SEL_E1S_FIRST  = 5'h1c;
  localparam logic [4:0]  SEL_E1G_FIRST  = 5'h1e;
  localparam int          SEL_HI_BIT     = 4;
  localparam int          SEL_MID_BIT    = 3;
  localparam int          SEL_CABLE_BIT  = 0;

  // one arbitrary pulse segment
  typedef struct packed {
    logic       sign;
    logic [6:0] mag;
  } tle_segment_s;

  typedef tle_segment_s [7:0] tle_segments_t;

  // sampled transmit rails
  typedef struct packed {
    logic pos;
    logic neg;
  } tle_rails_s;

  // configuration carried into the link domain
  typedef struct packed {
    logic dual_rail;
    logic host_mode;
    logic ami_bit;
    logic e1_mode;
    logic rise_edge;
  } tle_cfg_s;

  // decoded selector
  typedef struct packed {
    logic       valid;
    logic       e1;
    logic       gain;
    logic       arbitrary;
    logic       cable_120;
    logic [2:0] buildout;
  } tle_mode_s;

  // selector to mode and pulse shape
  function automatic tle_mode_s tle_decode(input logic [4:0] sel);
    tle_mode_s  m;
    logic [4:0] off;
    m        = '0;
    off      = '0;
    m.e1     = sel[SEL_HI_BIT] & sel[SEL_MID_BIT];
    if (sel >= SEL_T1S_FIRST && sel < SEL_T1S_ARB)
    begin
      off        = sel - SEL_T1S_FIRST;
      m.valid    = 1'b1;
      m.buildout = off[2:0];
    end
    else if (sel == SEL_T1S_ARB)
    begin
      m.valid     = 1'b1;
      m.arbitrary = 1'b1;
    end
    else if (sel >= SEL_T1G_FIRST && sel < SEL_T1G_ARB)
    begin
      off        = sel - SEL_T1G_FIRST;
      m.valid    = 1'b1;
      m.gain     = 1'b1;
      m.buildout = off[2:0];
    end
    else if (sel == SEL_T1G_ARB)
    begin
      m.valid     = 1'b1;
      m.gain      = 1'b1;
      m.arbitrary = 1'b1;
    end
    else if (sel >= SEL_E1S_FIRST)
    begin
      m.valid     = 1'b1;
      m.gain      = (sel >= SEL_E1G_FIRST);
      m.cable_120 = sel[SEL_CABLE_BIT];
    end
    return m;
  endfunction

endpackage

/* tle_edge_capture.sv */
// transmit rail capture on the selected transmit clock edge
`timescale 1ns/1ps
`default_nettype none
module tle_edge_capture
(
  // link clock and reset
  input  wire logic               clk_link,
  input  wire logic               rst_link,
  // edge choice, high samples on the rising edge
  input  wire logic               rise_edge,
  // rails from the framer
  input  wire logic               pos_in,
  input  wire logic               neg_in,
  // captured rails, aligned to the rising edge
  output var tle_pkg::tle_rails_s rails
);

  tle_pkg::tle_rails_s fall_reg;
  tle_pkg::tle_rails_s rails_reg;

  // falling edge capture, retimed below so the rest sees one edge
  always_ff @(negedge clk_link)
  begin
    if (rst_link)
      fall_reg <= '0;
    else
      fall_reg <= '{pos: pos_in, neg: neg_in};
  end

  // edge selection
  // falling-edge data is half a period old here, which costs one half cycle of latency
  always_ff @(posedge clk_link)
  begin
    if (rst_link)
      rails_reg <= '0;
    else if (rise_edge)
      rails_reg <= '{pos: pos_in, neg: neg_in};
    else
      rails_reg <= fall_reg;
  end

  assign rails = rails_reg;

endmodule
`default_nettype wire

/* tle_line_encoder.sv */
// transmit line encoder: capture, substitution, bipolar output, driver monitor, shaper
`timescale 1ns/1ps
`default_nettype none
module tle_line_encoder
#(
  parameter logic [3:0] SEG_CYCLES = 4'h1
)
(
  // system side clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // configuration levels
  input  wire logic                  rail_format_select,
  input  wire logic                  host_mode,
  input  wire logic                  line_code_select_bit,
  input  wire logic                  tx_sample_edge_select,
  input  wire logic [4:0]            equalizer_buildout_select,
  input  wire logic                  driver_failure_irq_enable,
  input  wire tle_pkg::tle_segments_t arbitrary_segments,
  // link side from the framer
  input  wire logic                  transmit_clock_in,
  input  wire logic                  tx_positive_or_serial_data,
  input  wire logic                  tx_negative_or_code_select,
  // bipolar line pulses, link domain
  output logic                       line_out_tip,
  output logic                       line_out_ring,
  // status
  output logic                       driver_failure_flag,
  output logic                       driver_failure_irq,
  // decoded mode
  output logic                       e1_mode,
  output logic                       gain_mode,
  output logic                       arbitrary_sel,
  output logic                       cable_120,
  output logic [2:0]                 line_build_out,
  // shaper drive, master clock timed
  output logic                       shape_active,
  output logic                       shape_sign,
  output logic [6:0]                 shape_magnitude
);

  //----------------------------------------------------------------------------
  // reset into the link domain
  //----------------------------------------------------------------------------
  logic rst_l1_reg;
  logic rst_link;

  // two stages so the link reset releases clean on the link clock
  always_ff @(posedge transmit_clock_in)
  begin
    rst_l1_reg <= rst;
    rst_link   <= rst_l1_reg;
  end

  //----------------------------------------------------------------------------
  // link domain state
  //----------------------------------------------------------------------------
  typedef struct packed {
    tle_pkg::tle_cfg_s          cfg1;
    tle_pkg::tle_cfg_s          cfg2;
    tle_pkg::tle_sym_e [7:0]    slot;
    logic [3:0]                 zrun;
    logic                       parity;
    logic                       pol;
    logic                       tip;
    logic                       ring;
    logic [7:0]                 idle;
    logic                       fail;
    logic                       tog_p;
    logic                       tog_n;
  } tle_link_s;

  tle_link_s           lk_reg;
  tle_link_s           lk_next;
  tle_pkg::tle_rails_s rails;
  tle_pkg::tle_cfg_s   cfg_sys;

  // config gathered on the system side, quasi-static, two flops each
  assign cfg_sys = '{dual_rail: rail_format_select, host_mode: host_mode, ami_bit: line_code_select_bit,
                     e1_mode: equalizer_buildout_select[tle_pkg::SEL_HI_BIT]
                              & equalizer_buildout_select[tle_pkg::SEL_MID_BIT],
                     rise_edge: tx_sample_edge_select};

  tle_edge_capture u_capture
  (
    .clk_link  (transmit_clock_in),
    .rst_link  (rst_link),
    .rise_edge (lk_reg.cfg2.rise_edge),
    .pos_in    (tx_positive_or_serial_data),
    .neg_in    (tx_negative_or_code_select),
    .rails     (rails)
  );

  // encoder and monitor next state
  always_comb
  begin
    logic               single;
    logic               ami;
    logic               pulse;
    logic               pol_out;
    tle_pkg::tle_sym_e  out_sym;
    single  = 1'b0;
    ami     = 1'b0;
    pulse   = 1'b0;
    pol_out = 1'b0;
    out_sym = tle_pkg::SYM_ZERO;
    lk_next = lk_reg;
    lk_next.cfg1 = cfg_sys;
    lk_next.cfg2 = lk_reg.cfg1;
    single = ~lk_reg.cfg2.dual_rail;
    // code pin in hardware control, code bit in host control
    ami = lk_reg.cfg2.host_mode ? lk_reg.cfg2.ami_bit : rails.neg;
    // polarity of the symbol leaving the delay line
    out_sym = lk_reg.slot[tle_pkg::DELAY_DEPTH-1];
    case (out_sym)
      tle_pkg::SYM_ONE, tle_pkg::SYM_BAL:
      begin
        pulse   = 1'b1;
        pol_out = ~lk_reg.pol;
      end
      tle_pkg::SYM_VIOL:
      begin
        pulse   = 1'b1;
        pol_out = lk_reg.pol;
      end
      default:
      begin
        pulse   = 1'b0;
        pol_out = lk_reg.pol;
      end
    endcase
    lk_next.pol = pol_out;
    // serial data on the positive rail enters the delay line
    lk_next.slot = {lk_reg.slot[tle_pkg::DELAY_DEPTH-2:0],
                    rails.pos ? tle_pkg::SYM_ONE : tle_pkg::SYM_ZERO};
    if (rails.pos)
    begin
      lk_next.zrun   = '0;
      lk_next.parity = ~lk_reg.parity;
    end
    else if (lk_reg.zrun != tle_pkg::RUN_SAT)
      lk_next.zrun = lk_reg.zrun + 4'h1;
    if (single && !ami)
    begin
      if (lk_reg.cfg2.e1_mode && lk_next.zrun == tle_pkg::HDB3_RUN)
      begin
        // HDB3 choice by pulse parity since the last substitution
        lk_next.slot[tle_pkg::HDB3_V_SLOT] = tle_pkg::SYM_VIOL;
        if (!lk_reg.parity)
          lk_next.slot[tle_pkg::HDB3_B_SLOT] = tle_pkg::SYM_BAL;
        lk_next.zrun   = '0;
        lk_next.parity = 1'b0;
      end
      else if (!lk_reg.cfg2.e1_mode && lk_next.zrun == tle_pkg::B8ZS_RUN)
      begin
        lk_next.slot[tle_pkg::B8ZS_V1_SLOT] = tle_pkg::SYM_VIOL;
        lk_next.slot[tle_pkg::B8ZS_B1_SLOT] = tle_pkg::SYM_BAL;
        lk_next.slot[tle_pkg::B8ZS_V2_SLOT] = tle_pkg::SYM_VIOL;
        lk_next.slot[tle_pkg::B8ZS_B2_SLOT] = tle_pkg::SYM_BAL;
        lk_next.zrun = '0;
      end
    end
    // bipolar output, dual rail straight through
    if (single)
    begin
      lk_next.tip  = pulse & pol_out;
      lk_next.ring = pulse & ~pol_out;
    end
    else
    begin
      lk_next.tip  = rails.pos;
      lk_next.ring = rails.neg;
    end
    if (lk_next.tip || lk_next.ring)
      lk_next.idle = '0;
    else if (lk_reg.idle <= tle_pkg::IDLE_LIMIT)
      lk_next.idle = lk_reg.idle + 8'h01;
    lk_next.fail = (lk_next.idle > tle_pkg::IDLE_LIMIT);
    // events toward the shaper, one toggle per polarity
    lk_next.tog_p = lk_reg.tog_p ^ lk_next.tip;
    lk_next.tog_n = lk_reg.tog_n ^ lk_next.ring;
  end

  // link registers
  // config keeps crossing during reset, else the first edges after release would sample on the wrong edge
  always_ff @(posedge transmit_clock_in)
  begin
    if (rst_link)
    begin
      lk_reg      <= '0;
      lk_reg.cfg1 <= cfg_sys;
      lk_reg.cfg2 <= lk_reg.cfg1;
    end
    else
      lk_reg <= lk_next;
  end

  assign line_out_tip  = lk_reg.tip;
  assign line_out_ring = lk_reg.ring;

  //----------------------------------------------------------------------------
  // system domain state
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic                   fail_s1;
    logic                   fail_s2;
    logic                   tp_s1;
    logic                   tp_s2;
    logic                   tp_s3;
    logic                   tn_s1;
    logic                   tn_s2;
    logic                   tn_s3;
    logic                   flag;
    logic                   irq;
    tle_pkg::tle_mode_s     mode;
    tle_pkg::tle_shape_e    state;
    logic [2:0]             seg;
    logic [3:0]             timer;
    logic                   neg;
    logic                   sign;
    logic [6:0]             mag;
    logic                   active;
  } tle_sys_s;

  tle_sys_s sy_reg;
  tle_sys_s sy_next;

  // status, decode and shaper next state
  always_comb
  begin
    logic                  ev_p;
    logic                  ev_n;
    tle_pkg::tle_segment_s segv;
    ev_p    = 1'b0;
    ev_n    = 1'b0;
    segv    = '0;
    sy_next = sy_reg;
    sy_next.fail_s1 = lk_reg.fail;
    sy_next.fail_s2 = sy_reg.fail_s1;
    sy_next.tp_s1   = lk_reg.tog_p;
    sy_next.tp_s2   = sy_reg.tp_s1;
    sy_next.tp_s3   = sy_reg.tp_s2;
    sy_next.tn_s1   = lk_reg.tog_n;
    sy_next.tn_s2   = sy_reg.tn_s1;
    sy_next.tn_s3   = sy_reg.tn_s2;
    sy_next.flag = sy_reg.fail_s2;
    sy_next.irq  = (sy_reg.fail_s2 != sy_reg.flag) & driver_failure_irq_enable;
    sy_next.mode = tle_pkg::tle_decode(equalizer_buildout_select);
    // shaper timed by the master clock; pulses during a run are merged
    ev_p = sy_reg.tp_s2 ^ sy_reg.tp_s3;
    ev_n = sy_reg.tn_s2 ^ sy_reg.tn_s3;
    case (sy_reg.state)
      tle_pkg::SHP_IDLE:
      begin
        sy_next.mag    = '0;
        sy_next.sign   = 1'b0;
        sy_next.active = 1'b0;
        if (ev_p || ev_n)
        begin
          sy_next.state = tle_pkg::SHP_RUN;
          sy_next.seg   = '0;
          sy_next.timer = '0;
          sy_next.neg   = ev_n & ~ev_p;
        end
      end
      tle_pkg::SHP_RUN:
      begin
        // eight signed segments for the arbitrary T1 pulse
        segv = arbitrary_segments[sy_reg.seg];
        // active shares the register stage of the segment it frames
        sy_next.active = 1'b1;
        if (sy_reg.mode.arbitrary && !sy_reg.mode.e1)
        begin
          sy_next.mag  = segv.mag;
          sy_next.sign = segv.sign ^ sy_reg.neg;
        end
        else
        begin
          sy_next.mag  = tle_pkg::FIXED_MAG;
          sy_next.sign = ~sy_reg.neg;
        end
        if (sy_reg.timer >= SEG_CYCLES - 4'h1)
        begin
          sy_next.timer = '0;
          sy_next.seg   = sy_reg.seg + 3'h1;
          if (sy_reg.seg == tle_pkg::LAST_SEGMENT)
            sy_next.state = tle_pkg::SHP_IDLE;
        end
        else
          sy_next.timer = sy_reg.timer + 4'h1;
      end
      default:
        sy_next.state = tle_pkg::SHP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sy_reg <= '0;
    else
      sy_reg <= sy_next;
  end

  assign driver_failure_flag = sy_reg.flag;
  assign driver_failure_irq  = sy_reg.irq;
  assign e1_mode             = sy_reg.mode.e1;
  assign gain_mode           = sy_reg.mode.gain;
  assign arbitrary_sel       = sy_reg.mode.arbitrary;
  assign cable_120           = sy_reg.mode.cable_120;
  assign line_build_out      = sy_reg.mode.buildout;
  assign shape_active        = sy_reg.active;
  assign shape_sign          = sy_reg.sign;
  assign shape_magnitude     = sy_reg.mag;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  logic [3:0] out_zeros;
  logic [7:0] quiet;
  logic       armed;
  logic       last_pos;
  logic       sub_on;
  logic       sub_hdb3;
  logic       sub_b8zs;

  // substitution in force by code pin or code bit
  assign sub_on   = ~lk_reg.cfg2.dual_rail & (lk_reg.cfg2.host_mode ? ~lk_reg.cfg2.ami_bit : ~rails.neg);
  assign sub_hdb3 = sub_on & lk_reg.cfg2.e1_mode;
  assign sub_b8zs = sub_on & ~lk_reg.cfg2.e1_mode;

  // helper: line zeros after the first pulse, idle run and last pulse polarity
  // zeros flushed from the delay line after reset are never substituted, so counting waits for a pulse
  always_ff @(posedge transmit_clock_in)
  begin
    if (rst_link || !(sub_hdb3 || sub_b8zs))
    begin
      out_zeros <= '0;
      armed     <= 1'b0;
    end
    else if (lk_reg.tip || lk_reg.ring)
    begin
      out_zeros <= '0;
      armed     <= 1'b1;
    end
    else if (armed && out_zeros != tle_pkg::RUN_SAT)
      out_zeros <= out_zeros + 4'h1;
    if (rst_link || lk_reg.tip || lk_reg.ring)
      quiet <= '0;
    else if (quiet != 8'hff)
      quiet <= quiet + 8'h01;
    if (rst_link)
      last_pos <= 1'b0;
    else if (lk_reg.tip || lk_reg.ring)
      last_pos <= lk_reg.tip;
  end

  chk_bipolar_excl: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    line_out_tip |-> !line_out_ring) else $error("both line rails driven");

  chk_hdb3_zero_run: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    sub_hdb3 && $stable(lk_reg.cfg2) |-> out_zeros <= 4'h4) else $error("hdb3 left four zeros");

  chk_b8zs_zero_run: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    sub_b8zs && $stable(lk_reg.cfg2) |-> out_zeros <= 4'h8) else $error("b8zs left eight zeros");

  chk_dual_passthru: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    lk_reg.cfg2.dual_rail |=> line_out_tip == $past(rails.pos) && line_out_ring == $past(rails.neg))
    else $error("dual rail not passed through");

  chk_fail_set: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    quiet > tle_pkg::IDLE_LIMIT && !(line_out_tip || line_out_ring) |-> lk_reg.fail)
    else $error("failure not raised after idle");

  chk_fail_clear: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    (line_out_tip || line_out_ring) |-> !lk_reg.fail && lk_reg.idle == 8'h00)
    else $error("failure held over a pulse");

  chk_ami_alternate: assert property (@(posedge transmit_clock_in) disable iff (rst_link)
    !lk_reg.cfg2.dual_rail && lk_reg.cfg2.host_mode && lk_reg.cfg2.ami_bit && $stable(lk_reg.cfg2)
    && line_out_tip |-> !last_pos) else $error("ami pulses not alternating");

  chk_irq_change: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(driver_failure_flag) && $past(driver_failure_irq_enable) |-> driver_failure_irq)
    else $error("status change without interrupt");

  chk_e1_decode: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> e1_mode == ($past(equalizer_buildout_select[4]) & $past(equalizer_buildout_select[3])))
    else $error("e1 mode decode wrong");

  chk_reset_flag: assert property (@(posedge clk_sys)
    $past(rst) |-> !driver_failure_flag && !driver_failure_irq) else $error("flag set after reset");

  chk_shape_idle: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(shape_active) |-> $past(sy_reg.seg, 2) == tle_pkg::LAST_SEGMENT) else $error("shaper ended off segment count");

endmodule
`default_nettype wire

/* tle_line_encoder_fix_note.sv */
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tle_framer_model.sv */
// framer model that drives the transmit link clock and rails
`timescale 1ns/1ps
`default_nettype none
module tle_framer_model
(
  // link outputs
  output logic      clk_link,
  output logic      pos,
  output logic      neg,
  // levels from the bench
  input  wire logic rise,
  input  wire logic dual,
  input  wire logic code
);
  logic nd;

  // clock stands low outside frames
  initial
  begin
    clk_link = 1'b0;
    pos = 1'b0;
    nd = 1'b1;
  end

  // code level in single rail, negative rail in dual rail
  assign neg = dual ? nd : code;

  // clock plus data
  // a bit is valid only 3 ns either side of the chosen edge, so a wrong edge sees its inverse
  task automatic send(input logic [63:0] p, input logic [63:0] n, input int len);
    for (int i = len - 1; i >= 0; i--)
    begin
      if (rise)
      begin
        pos = p[i];
        nd = n[i];
        #3 clk_link = 1'b1;
        #3 pos = ~p[i];
        nd = ~n[i];
        #3 clk_link = 1'b0;
        #3;
      end
      else
      begin
        clk_link = 1'b1;
        #3 pos = p[i];
        nd = n[i];
        #3 clk_link = 1'b0;
        #3 pos = ~p[i];
        nd = ~n[i];
        #3;
      end
    end
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking testbench for the transmit line encoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   clk_sys, rst, rail, host, code_bit, code, edge_s, irq_en, cap, seen_sign;
  logic                   lclk, pos, neg, tip, ring, flag, irq, e1, gain, arb, cab, act, sgn;
  logic [4:0]             sel;
  logic [2:0]             bo;
  logic [6:0]             mag, seen_mag;
  tle_pkg::tle_segments_t segs;
  int                     fail_count, n_tests, cyc, irq_n;
  string                  line_s;
  logic [11:0]            dt [10] = '{12'h400, 12'h604, 12'h690, 12'h720, 12'h924,
                                      12'h9b0, 12'he40, 12'hec8, 12'hf60, 12'hfe8};

  //----------------------------------------
  // instances
  //----------------------------------------
  tle_line_encoder tle_line_encoder_inst (.clk_sys(clk_sys), .rst(rst), .rail_format_select(rail),
    .host_mode(host), .line_code_select_bit(code_bit), .tx_sample_edge_select(edge_s),
    .equalizer_buildout_select(sel), .driver_failure_irq_enable(irq_en), .arbitrary_segments(segs),
    .transmit_clock_in(lclk), .tx_positive_or_serial_data(pos), .tx_negative_or_code_select(neg),
    .line_out_tip(tip), .line_out_ring(ring), .driver_failure_flag(flag), .driver_failure_irq(irq),
    .e1_mode(e1), .gain_mode(gain), .arbitrary_sel(arb), .cable_120(cab), .line_build_out(bo),
    .shape_active(act), .shape_sign(sgn), .shape_magnitude(mag));
  tle_framer_model tle_framer_model_inst (.clk_link(lclk), .pos(pos), .neg(neg), .rise(edge_s),
    .dual(rail), .code(code));

  //----------------------------------------
  // clock, monitors and hang guard
  //----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // line symbols, one per link cycle
  always @(posedge lclk)
    if (cap) line_s = {line_s, tip === 1'b1 ? "+" : ring === 1'b1 ? "-" : "0"};
  // last shaper segment and interrupt count
  always @(posedge clk_sys)
  begin
    cyc++;
    if (act === 1'b1)
    begin
      seen_mag = mag;
      seen_sign = sgn;
    end
    if (irq === 1'b1) irq_n++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  //----------------------------------------
  // tasks
  //----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (exp !== got)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // compare from the first pulse on, leading zeros are latency
  task automatic chs(input string nm, input string exp);
    string got;
    int i;
    i = 0;
    while (i < line_s.len() && line_s[i] == "0") i++;
    got = line_s.substr(i, i + exp.len() - 1);
    n_tests++;
    if (got != exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %s seen %s", nm, exp, got);
    end
  endtask
  // reset with new levels, then one frame; leading zeros cover link reset release
  task automatic go(input logic [4:0] c, input logic [4:0] s, input logic [63:0] p,
                    input logic [63:0] n, input int len, input string nm, input string exp);
    @(posedge clk_sys);
    #1 {rail, host, code_bit, code, edge_s} = c;
    sel = s;
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    tle_framer_model_inst.send(64'h0, 64'h0, 6);
    @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("flag_reset", 16'h0, {15'h0, flag});
    #5 line_s = "";
    cap = 1'b1;
    tle_framer_model_inst.send(p, n, len);
    tle_framer_model_inst.send(64'h0, 64'h0, 14);
    cap = 1'b0;
    chs(nm, exp);
  endtask
  task automatic idle(input int len);
    tle_framer_model_inst.send(64'h1000 & {64{len == 13}}, 64'h0, len);
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial
  begin
    // reset held from time zero so no check sees state before the first reset
    {rst, rail, host, code_bit, code, edge_s, cap} = 7'h40;
    irq_en = 1'b1;
    sel = 5'h08;
    segs = {8'h2a, {7{8'h91}}};
    go(5'b00000, 5'h1c, 64'b000100001100001, 64'h0, 15, "hdb3", "+000+-+-00-+");
    go(5'b00001, 5'h08, 64'b0001000000001000000001, 64'h0, 22, "b8zs", "+000+-0-+-000-+0+-+");
    go(5'b01100, 5'h1f, 64'b000100001, 64'h0, 9, "ami_bit", "+0000-");
    go(5'b00010, 5'h0e, 64'b0001000000001, 64'h0, 13, "ami_pin", "+00000000-");
    go(5'b10000, 5'h08, 64'b0001000000000, 64'b0000000000001, 13, "dual", "+00000000-");
    go(5'b00010, 5'h0d, 64'b0001, 64'h0, 4, "arb", "+");
    repeat (20) @(posedge clk_sys);
    chk("seg_mag", {9'h0, 7'h2a}, {9'h0, seen_mag});
    chk("seg_sign", 16'h0, {15'h0, seen_sign});
    irq_n = 0;
    idle(60);
    idle(60);
    chk("flag_early", 16'h0, {15'h0, flag});
    idle(10);
    chk("flag_set", 16'h1, {15'h0, flag});
    idle(13);
    chk("flag_clear", 16'h0, {15'h0, flag});
    chk("irq_count", 16'h2, irq_n[15:0]);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_sys);
      #1 sel = dt[i][11:7];
      repeat (3) @(posedge clk_sys);
      chk("decode", {9'h0, dt[i][6:0]}, {9'h0, e1, gain, arb, cab, bo});
    end
    wrap_up();
  end
endmodule
`default_nettype wire
